/* File: design/pager_pkg.sv */
// Purpose: Shared constants and types for the paging frame packet builder.
// Assumes: 10 MHz pclk; deinterleaved codewords arrive in block order.
// Notes:   Field positions refer to the 21 information bits of a codeword.
package pager_pkg;
   localparam int CLK_HZ        = 10_000_000;
   localparam int FRAME_TIME_US = 1_875_000;
   localparam int FRAME_CYCLES  = FRAME_TIME_US * (CLK_HZ / 1_000_000);
   localparam int BLOCKS        = 11;
   localparam logic [3:0] LAST_BLOCK = 4'hA;
   localparam logic [6:0] LAST_WORD  = 7'h57;
   localparam logic [3:0] MAX_CYCLE  = 4'hE;
   // Rate codes reported by the second sync.
   localparam logic [1:0] RATE_1600 = 2'h0;
   localparam logic [1:0] RATE_3200 = 2'h1;
   localparam logic [1:0] RATE_6400 = 2'h2;
   // Register byte offsets.
   localparam logic [7:0] A_CTRL   = 8'h00;
   localparam logic [7:0] A_FRAME  = 8'h04;
   localparam logic [7:0] A_ADDR1  = 8'h08;
   localparam logic [7:0] A_ADDR2  = 8'h0C;
   localparam logic [7:0] A_ACFG   = 8'h10;
   localparam logic [7:0] A_STATUS = 8'h14;
   localparam int CTRL_EN  = 0;
   localparam int CTRL_TIF = 1;
   localparam int ACFG_LONG = 0;
   localparam int ACFG_TONE = 1;
   localparam int FRM_MASK_LSB = 8;
   localparam logic [1:0]  CTRL_RST  = 2'h0;
   localparam logic [13:0] FRAME_RST = 14'h0000;
   localparam logic [20:0] ADDR_RST  = 21'h000000;
   localparam logic [1:0]  ACFG_RST  = 2'h0;
   // Codeword information layouts.
   localparam int BIW_F_LSB  = 0;
   localparam int BIW_S_LSB  = 3;
   localparam int B1_XTR_LSB = 0;
   localparam int B1_VS_LSB  = 2;
   localparam int VEC_MS_LSB = 0;
   localparam int VEC_ML_LSB = 7;
   // Block information word formats and time field limits.
   localparam logic [2:0] F_DATE = 3'h1;
   localparam logic [2:0] F_TIME = 3'h2;
   localparam logic [2:0] F_ZONE = 3'h5;
   localparam logic [3:0] SYS_T0 = 4'h4;
   localparam logic [3:0] SYS_T1 = 4'h5;
   localparam logic [5:0] MIN_MAX   = 6'h3B;
   localparam logic [4:0] HOUR_MAX  = 5'h17;
   localparam logic [4:0] ZONE_MAX  = 5'h0F;
   localparam logic [3:0] MONTH_MAX = 4'hC;
   // Packet types.
   localparam logic [1:0] PKT_BIW  = 2'h0;
   localparam logic [1:0] PKT_ADDR = 2'h1;
   localparam logic [1:0] PKT_VEC  = 2'h2;
   localparam logic [1:0] PKT_MSG  = 2'h3;
   typedef enum logic [2:0] {ST_IDLE, ST_FIW, ST_SYNC2, ST_DATA, ST_SAVE}
      dec_state_t;
endpackage

/* File: design/pager_frame_packet_builder.sv */
// Purpose: Frame structure tracker and host packet builder for a pager.
// Assumes: Words arrive deinterleaved, block by block, phase by phase.
// Notes:   One user address, short or long; packets are 40 bits wide.
// Contract
// - Year is five bits modulo 32, passed unchanged to the host.
// - Coarse seconds are three bits in 7.5 second steps, passed unchanged.
// - Minute above 59 is flagged as an error in the packet.
// - Hour above 23 is flagged as an error in the packet.
// - Accurate seconds in 1/64 minute units are passed unchanged.
// - Daylight bit one means standard time; passed unchanged.
// - Zone codes 0 to 15 are valid; higher codes are flagged.
// - Only assigned frames are processed; others battery save.
// - A frame is sync then exactly eleven blocks of data.
// - Rate selects one, two or four phases.
// - Eight words per block per phase, words numbered 0 to 87.
// - Sync one, frame info with frame and cycle, then sync two.
// - Field boundaries are tracked per phase, apart from block bounds.
// - Short or long address; non tone address pairs with a vector.
// - For long address, word after vector is first message word.
// - Battery save when no address hit by end of address fields.
// - Packets go out block by block and phase by phase.
// - The first block information word of a phase is never sent.
// - Block info packets carry error, phase code and format code.
// - Time and date words are sent only while forwarding is enabled.
//
// The address map and register access over APB are this design's own decisions.
module pager_frame_packet_builder
   import pager_pkg::*;
#(
   parameter int FRAME_CYC = pager_pkg::FRAME_CYCLES
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        sync1_det,
   input  wire logic        fiw_valid,
   input  wire logic [6:0]  fiw_frame,
   input  wire logic [3:0]  fiw_cycle,
   input  wire logic        sync2_det,
   input  wire logic [1:0]  sync2_rate,
   input  wire logic        cw_valid,
   output logic             cw_ready,
   input  wire logic [20:0] cw_info,
   input  wire logic        cw_err,
   output logic             pkt_valid,
   input  wire logic        pkt_ready,
   output logic      [39:0] pkt_data,
   output logic             battery_save
);
   import pager_pkg::*;

   dec_state_t  state_r;
   logic [1:0]  ctrl_r;
   logic [13:0] frm_r;
   logic [20:0] addr1_r;
   logic [20:0] addr2_r;
   logic [1:0]  acfg_r;
   logic [31:0] prdata_r;
   logic [6:0]  frame_r;
   logic [3:0]  cycle_r;
   logic [1:0]  rate_r;
   logic [31:0] tmr_r;
   logic [2:0]  widx_r;
   logic [1:0]  pidx_r;
   logic [3:0]  blk_r;
   logic        pkt_valid_r;
   logic [39:0] pkt_data_r;
   logic        bsave_r;

   // Register decode; the slave always answers in the access cycle.
   wire sel_ctrl = paddr == A_CTRL;
   wire sel_frm  = paddr == A_FRAME;
   wire sel_a1   = paddr == A_ADDR1;
   wire sel_a2   = paddr == A_ADDR2;
   wire sel_acfg = paddr == A_ACFG;
   wire sel_stat = paddr == A_STATUS;
   wire mapped   = sel_ctrl | sel_frm | sel_a1 | sel_a2 | sel_acfg | sel_stat;
   wire apb_wr   = psel & penable & pwrite & mapped;
   wire apb_setup_rd = psel & ~penable & ~pwrite;
   wire [31:0] status_w = {17'h00000, bsave_r, state_r == ST_DATA,
                           rate_r, cycle_r, frame_r};
   wire [31:0] rd_mux =
      sel_ctrl ? {30'h0, ctrl_r}   : sel_frm  ? {18'h0, frm_r}  :
      sel_a1   ? {11'h0, addr1_r}  : sel_a2   ? {11'h0, addr2_r} :
      sel_acfg ? {30'h0, acfg_r}   : sel_stat ? status_w : 32'h0;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata  = prdata_r;

   // Read data is captured in the setup cycle so it comes from a flop.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_r   <= CTRL_RST;
         frm_r    <= FRAME_RST;
         addr1_r  <= ADDR_RST;
         addr2_r  <= ADDR_RST;
         acfg_r   <= ACFG_RST;
         prdata_r <= 32'h0;
      end
      else
      begin
         if (apb_wr && sel_ctrl) ctrl_r  <= pwdata[1:0];
         if (apb_wr && sel_frm)  frm_r   <= pwdata[13:0];
         if (apb_wr && sel_a1)   addr1_r <= pwdata[20:0];
         if (apb_wr && sel_a2)   addr2_r <= pwdata[20:0];
         if (apb_wr && sel_acfg) acfg_r  <= pwdata[1:0];
         if (apb_setup_rd)       prdata_r <= rd_mux;
      end
   end

   // Frame level sequencing and word position within the frame.
   wire        en       = ctrl_r[CTRL_EN];
   wire        tif_en   = ctrl_r[CTRL_TIF];
   wire        cfg_long = acfg_r[ACFG_LONG];
   wire        cfg_tone = acfg_r[ACFG_TONE];
   wire [6:0]  fmask    = frm_r[FRM_MASK_LSB +: 7];
   wire        assigned = ((fiw_frame ^ frm_r[6:0]) & ~fmask) == 7'h00;
   wire        fiw_ok   = en && assigned && fiw_cycle <= MAX_CYCLE;
   wire [1:0]  nph_last = rate_r == RATE_6400 ? 2'h3 :
                          rate_r == RATE_3200 ? 2'h1 : 2'h0;
   wire [1:0]  ph_code  = rate_r == RATE_3200 ? {pidx_r[0], 1'b0} : pidx_r;
   wire [6:0]  word_no  = {blk_r, widx_r};
   assign cw_ready = ~pkt_valid_r | pkt_ready;
   wire        take      = cw_valid & cw_ready;
   wire        data_take = take & (state_r == ST_DATA);
   wire        blk_end   = widx_r == 3'h7 && pidx_r == nph_last;
   wire        last_word = blk_end && blk_r == LAST_BLOCK;
   wire        tmr_out   = tmr_r >= 32'(FRAME_CYC - 1);
   logic       save_go;

   // The frame timer guards against a lost sync leaving the tracker stuck.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r <= ST_IDLE;
         frame_r <= 7'h00;
         cycle_r <= 4'h0;
         rate_r  <= RATE_1600;
         tmr_r   <= 32'h0;
         widx_r  <= 3'h0;
         pidx_r  <= 2'h0;
         blk_r   <= 4'h0;
         bsave_r <= 1'b0;
      end
      else if (sync1_det && en)
      begin
         state_r <= ST_FIW;
         tmr_r   <= 32'h0;
         bsave_r <= 1'b0;
      end
      else
      begin
         if (state_r != ST_IDLE) tmr_r <= tmr_r + 32'h1;
         case (state_r)
            ST_IDLE: bsave_r <= 1'b1;
            ST_FIW:
               if (fiw_valid)
               begin
                  frame_r <= fiw_frame;
                  cycle_r <= fiw_cycle;
                  state_r <= fiw_ok ? ST_SYNC2 : ST_SAVE;
                  bsave_r <= ~fiw_ok;
               end
            ST_SYNC2:
               if (sync2_det)
               begin
                  rate_r  <= sync2_rate;
                  state_r <= ST_DATA;
                  widx_r  <= 3'h0;
                  pidx_r  <= 2'h0;
                  blk_r   <= 4'h0;
               end
            ST_DATA:
               if (save_go)
               begin
                  state_r <= ST_SAVE;
                  bsave_r <= 1'b1;
               end
               else if (data_take)
               begin
                  widx_r <= widx_r + 3'h1;
                  if (widx_r == 3'h7)
                     pidx_r <= blk_end ? 2'h0 : pidx_r + 2'h1;
                  if (blk_end) blk_r <= blk_r + 4'h1;
                  if (last_word) state_r <= ST_IDLE;
               end
            ST_SAVE: bsave_r <= 1'b1;
            default: state_r <= ST_IDLE;
         endcase
         if (tmr_out && state_r != ST_IDLE) state_r <= ST_IDLE;
         if (!en) state_r <= ST_IDLE;
      end
   end
   assign battery_save = bsave_r;

   // Per phase field tracking, read back for the phase now arriving.
   logic [6:0] as_w [4];
   logic [6:0] vs_w [4];
   logic [6:0] vp_w [4];
   logic [6:0] ms_w [4];
   logic [7:0] me_w [4];
   logic [3:0] hit_w, vpend_w, lpend_w, mnext_w, mact_w, done_w;
   wire  [6:0] cur_as = as_w[pidx_r];
   wire  [6:0] cur_vs = vs_w[pidx_r];
   wire  [6:0] cur_vp = vp_w[pidx_r];
   wire  [6:0] cur_ms = ms_w[pidx_r];
   wire  [7:0] cur_me = me_w[pidx_r];
   wire        is_biw1 = word_no == 7'h00;
   wire        in_biw  = !is_biw1 && word_no < cur_as;
   wire        in_addr = !is_biw1 && word_no >= cur_as && word_no < cur_vs;
   wire        in_vect = !is_biw1 && word_no >= cur_vs;
   wire [6:0]  vec_slot = 7'(cur_vs + (word_no - cur_as));
   wire        a1_eq = !cw_err && cw_info == addr1_r;
   wire        a2_eq = !cw_err && cw_info == addr2_r;
   wire        lp    = lpend_w[pidx_r];
   wire        short_hit = in_addr && !lp && !cfg_long && a1_eq;
   wire        lng_first = in_addr && !lp && cfg_long && a1_eq;
   wire        lng_hit   = in_addr && lp && a2_eq;
   wire        addr_hit  = short_hit | lng_hit;
   wire        vec_hit   = vpend_w[pidx_r] && in_vect && word_no == cur_vp;
   wire        mnext_hit = mnext_w[pidx_r] && word_no == 7'(cur_vp + 7'h1);
   wire        mwin_hit  = mact_w[pidx_r] && word_no > cur_vp &&
                           word_no >= cur_ms && {1'b0, word_no} < cur_me;
   wire        msg_hit   = in_vect && (mnext_hit | mwin_hit);
   wire [6:0]  b1_as = 7'(cw_info[B1_XTR_LSB +: 2]) + 7'h01;
   wire [6:0]  v_ms  = cw_info[VEC_MS_LSB +: 7];
   wire [7:0]  v_me  = {1'b0, v_ms} + {2'b00, cw_info[VEC_ML_LSB +: 6]};
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_ph
         logic [6:0] as_r, vs_r, vp_r, ms_r;
         logic [7:0] me_r;
         logic       hit_r, vpend_r, lpend_r, mnext_r, mact_r, done_r;
         wire        here = data_take && pidx_r == 2'(g);
         // Each phase keeps its own field bounds and call progress.
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               {as_r, vs_r, vp_r, ms_r, me_r, hit_r, vpend_r, lpend_r,
                mnext_r, mact_r, done_r} <= 42'h0;
            else if (sync1_det)
               {as_r, vs_r, vp_r, ms_r, me_r, hit_r, vpend_r, lpend_r,
                mnext_r, mact_r, done_r} <= 42'h0;
            else if (here)
            begin
               if (is_biw1)
               begin
                  as_r <= b1_as;
                  vs_r <= cw_info[B1_VS_LSB +: 7];
               end
               if (in_vect) done_r <= 1'b1;
               lpend_r <= lng_first;
               if (lng_first | short_hit) vp_r <= vec_slot;
               if (addr_hit)
               begin
                  hit_r   <= 1'b1;
                  vpend_r <= ~cfg_tone;
               end
               if (vec_hit)
               begin
                  vpend_r <= 1'b0;
                  ms_r    <= v_ms;
                  me_r    <= v_me;
                  mact_r  <= 1'b1;
                  mnext_r <= cfg_long;
               end
               else if (mnext_hit) mnext_r <= 1'b0;
            end
         end
         assign as_w[g] = as_r;
         assign vs_w[g] = vs_r;
         assign vp_w[g] = vp_r;
         assign ms_w[g] = ms_r;
         assign me_w[g] = me_r;
         assign hit_w[g]   = hit_r;
         assign vpend_w[g] = vpend_r;
         assign lpend_w[g] = lpend_r;
         assign mnext_w[g] = mnext_r;
         assign mact_w[g]  = mact_r;
         assign done_w[g]  = done_r | (g > nph_last);
      end
   endgenerate
   assign save_go = (&done_w) && !(|hit_w);
   // Block information words: time fields are checked against their ranges.
   wire [2:0]  bf = cw_info[BIW_F_LSB +: 3];
   wire [13:0] bs = cw_info[BIW_S_LSB +: 14];
   wire        f_date = bf == F_DATE;
   wire        f_time = bf == F_TIME;
   wire        f_zone = bf == F_ZONE && (bs[3:0] == SYS_T0 ||
                                         bs[3:0] == SYS_T1);
   wire        bad_date = f_date && (bs[13:10] == 4'h0 ||
                          bs[13:10] > MONTH_MAX || bs[9:5] == 5'h00);
   wire        bad_time = f_time && (bs[10:5] > MIN_MAX ||
                                     bs[4:0] > HOUR_MAX);
   wire        bad_zone = f_zone && bs[8:4] > ZONE_MAX;
   wire        b_err = cw_err | bad_date | bad_time | bad_zone;
   wire        biw_fwd = in_biw && tif_en &&
                         (cw_err || f_date || f_time || f_zone);
   // Anything not matched here is dropped: other pagers' words, the first block info word, a long address first word.
   wire        emit = data_take && !save_go &&
                      (biw_fwd | addr_hit | vec_hit | msg_hit);
   wire [1:0]  pk_type = biw_fwd ? PKT_BIW : addr_hit ? PKT_ADDR :
                         vec_hit ? PKT_VEC : PKT_MSG;
   wire [6:0]  pk_word = short_hit ? vec_slot : lng_hit ? cur_vp : word_no;
   wire [20:0] pk_info = biw_fwd ? {4'h0, bf, bs} : cw_info;
   wire        pk_err  = biw_fwd ? b_err : cw_err;
   wire [39:0] pk_all  = {pk_type, pk_err, ph_code, pk_word, 7'h00, pk_info};

   // The output stage holds one packet; the input stalls while it is full and pkt_ready is low.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pkt_valid_r <= 1'b0;
         pkt_data_r  <= 40'h0;
      end
      else if (emit)
      begin
         pkt_valid_r <= 1'b1;
         pkt_data_r  <= pk_all;
      end
      else if (pkt_ready) pkt_valid_r <= 1'b0;
   end
   assign pkt_valid = pkt_valid_r;
   assign pkt_data  = pkt_data_r;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   biw1_drop_a: assert property (emit |-> word_no != 7'h00)
      else $error("first block info word forwarded");
   tif_gate_a: assert property (emit && pk_type == PKT_BIW |-> tif_en)
      else $error("block info sent while forwarding disabled");
   one_phase_a: assert property (emit && rate_r == RATE_1600
      |=> pkt_data_r[36:35] == 2'h0)
      else $error("phase other than A at single phase rate");
   word_range_a: assert property (state_r == ST_DATA
      |-> word_no <= LAST_WORD)
      else $error("word number beyond 87");
   frame_end_a: assert property (data_take && last_word && !save_go
      |=> state_r == ST_IDLE)
      else $error("frame did not end after eleventh block");
   phase_step_a: assert property (data_take && !save_go &&
      widx_r == 3'h7 && !blk_end |=> pidx_r == $past(pidx_r) + 2'h1)
      else $error("phase order broken");
   save_go_a: assert property (state_r == ST_DATA && save_go && !sync1_det &&
      en && !tmr_out |=> battery_save && state_r == ST_SAVE)
      else $error("no battery save after empty address fields");
   minute_err_a: assert property (emit && biw_fwd && f_time &&
      bs[10:5] > MIN_MAX |=> pkt_data_r[37])
      else $error("bad minute not flagged");
   cycle_chk_a: assert property (state_r == ST_FIW && fiw_valid &&
      fiw_cycle > MAX_CYCLE && !sync1_det |=> state_r != ST_SYNC2)
      else $error("bad cycle number accepted");
   pkt_hold_a: assert property (pkt_valid && !pkt_ready
      |=> pkt_valid && $stable(pkt_data))
      else $error("packet changed while stalled");
endmodule

/* File: tb/pager_host_model.sv */
// Purpose: Host side model that takes packets from the packet builder.
// Assumes: A packet is taken at an edge with pkt_valid and pkt_ready high.
// Notes:   Ready drops one cycle in three so held packets are exercised.
module pager_host_model
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        pkt_valid,
   input  wire logic [39:0] pkt_data,
   output logic             pkt_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [39:0] got[$];
   logic [1:0]  stall_r;
   // Packets are kept whole, phase and word number included, so that the
   // bench can sort interleaved calls apart.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stall_r   <= 2'h0;
         pkt_ready <= 1'b0;
      end
      else
      begin
         stall_r   <= (stall_r == 2'h2) ? 2'h0 : stall_r + 2'h1;
         pkt_ready <= (stall_r != 2'h2);
         if (pkt_valid && pkt_ready)
            got.push_back(pkt_data);
      end
   end
endmodule

/* File: tb/pager_frame_packet_builder_tb.sv */
// Purpose: Self-checking bench for the paging frame packet builder.
// Assumes: One user short address; the call sits in block 0 of phase A.
// Notes:   The frame timer is shortened so that a run stays brief.
module pager_frame_packet_builder_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import pager_pkg::*;
   localparam logic [20:0] MY_A = 21'h0ABCDE;
   localparam logic [20:0] VEC  = 21'h000105;
   localparam logic [20:0] MSG0 = 21'h1A5A5A;
   localparam logic [20:0] MSG1 = 21'h05A5A5;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        sync1_det, fiw_valid, sync2_det, cw_valid, cw_ready, cw_err;
   logic [6:0]  fiw_frame;
   logic [3:0]  fiw_cycle;
   logic [1:0]  sync2_rate;
   logic [20:0] cw_info;
   logic        pkt_valid, pkt_ready, battery_save, r;
   logic [39:0] pkt_data;
   logic [39:0] exp_q[$];
   int          n_mismatch, checks_done;
   pager_frame_packet_builder #(.FRAME_CYC(20000)) uut
   (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sync1_det(sync1_det), .fiw_valid(fiw_valid),
      .fiw_frame(fiw_frame), .fiw_cycle(fiw_cycle),
      .sync2_det(sync2_det), .sync2_rate(sync2_rate),
      .cw_valid(cw_valid), .cw_ready(cw_ready), .cw_info(cw_info),
      .cw_err(cw_err), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
      .pkt_data(pkt_data), .battery_save(battery_save)
   );
   pager_host_model host
   (
      .pclk(pclk), .presetn(presetn), .pkt_valid(pkt_valid),
      .pkt_data(pkt_data), .pkt_ready(pkt_ready)
   );
   // Free running bus clock.
   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task automatic finish_test();
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(logic [39:0] g, logic [39:0] e);
      checks_done++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   // APB master; the request stands until pready is seen at an edge.
   task automatic apb(logic [7:0] a, logic w, logic [31:0] d);
      psel    <= 1'b1;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      // Response is taken at the same rising edge that shows pready high.
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      r  = pslverr;
      rd = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Codeword stays offered until cw_ready is seen at an edge.
   task automatic send_cw(logic [20:0] v);
      cw_valid <= 1'b1;
      cw_info  <= v;
      @(posedge pclk);
      while (cw_ready !== 1'b1)
         @(posedge pclk);
   endtask
   task automatic syncs(logic [6:0] f, logic [3:0] c, logic [1:0] rt);
      sync1_det  <= 1'b1;
      @(posedge pclk);
      sync1_det  <= 1'b0;
      fiw_valid  <= 1'b1;
      fiw_frame  <= f;
      fiw_cycle  <= c;
      @(posedge pclk);
      fiw_valid  <= 1'b0;
      sync2_det  <= 1'b1;
      sync2_rate <= rt;
      @(posedge pclk);
      sync2_det  <= 1'b0;
   endtask
   function automatic logic [39:0] pk(logic [1:0] t, logic e,
      logic [1:0] ph, logic [6:0] w, logic [20:0] i);
      return {t, e, ph, w, 7'h00, i};
   endfunction
   // Phase A holds our call, other phases hold three time words and strangers.
   function automatic logic [20:0] word_of(logic [1:0] ph, int n);
      logic [20:0] a[8];
      logic [20:0] c[8];
      a = '{21'h00000C, MY_A, 21'h033333, VEC, 21'h00ABCD, MSG0, MSG1,
            21'h0FFFFF};
      c = '{21'h000017, {4'h0, 3'h7, 6'h3B, 5'h17, F_TIME},
            {4'h0, 3'h7, 6'h3B, 5'h18, F_TIME},
            {4'h0, 3'h0, 6'h3C, 5'h00, F_TIME}, 21'h054321,
            21'h000000, 21'h000000, 21'h000000};
      return (ph == 2'h0) ? a[n] : c[n];
   endfunction
   task automatic frame(logic [1:0] rt, logic tif, logic [3:0] cy);
      int np;
      logic [1:0] ph;
      np = (rt == RATE_6400) ? 4 : (rt == RATE_3200) ? 2 : 1;
      apb(A_CTRL, 1'b1, {30'h0, tif, 1'b1});
      host.got.delete();
      exp_q.delete();
      syncs(7'h05, cy, rt);
      for (int b = 0; b < BLOCKS; b++)
         for (int p = 0; p < np; p++)
            for (int n = 0; n < 8; n++)
            begin
               ph = (rt == RATE_6400) ? 2'(p) : 2'(p * 2);
               cw_err <= (rt == RATE_1600 && b == 0 && n == 5);
               send_cw((b == 0) ? word_of(ph, n) : 21'h000000);
               if (b == 0 && n == 7 && ph == 2'h0)
               begin
                  exp_q.push_back(pk(PKT_ADDR, 1'b0, ph, 7'h03, MY_A));
                  exp_q.push_back(pk(PKT_VEC, 1'b0, ph, 7'h03, VEC));
                  exp_q.push_back(pk(PKT_MSG, rt == RATE_1600, ph, 7'h05,
                     MSG0));
                  exp_q.push_back(pk(PKT_MSG, 1'b0, ph, 7'h06, MSG1));
               end
               else if (b == 0 && n == 7 && tif)
               begin
                  exp_q.push_back(pk(PKT_BIW, 1'b0, ph, 7'h01,
                     {4'h0, F_TIME, 3'h7, 6'h3B, 5'h17}));
                  exp_q.push_back(pk(PKT_BIW, 1'b1, ph, 7'h02,
                     {4'h0, F_TIME, 3'h7, 6'h3B, 5'h18}));
                  exp_q.push_back(pk(PKT_BIW, 1'b1, ph, 7'h03,
                     {4'h0, F_TIME, 3'h0, 6'h3C, 5'h00}));
               end
            end
      cw_valid <= 1'b0;
      chk(40'(battery_save), 40'h0);
      for (int i = 0; i < 300 && host.got.size() < exp_q.size(); i++)
         @(posedge pclk);
      repeat (20) @(posedge pclk);
      chk(40'(host.got.size()), 40'(exp_q.size()));
      foreach (exp_q[i])
         if (i < host.got.size())
            chk(host.got[i], exp_q[i]);
   endtask
   // Hang guard, far beyond the under one thousand cycles the tests need.
   initial
   begin
      repeat (60000) @(posedge pclk);
      n_mismatch++;
      finish_test();
   end
   initial
   begin
      {presetn, psel, penable, pwrite, sync1_det, fiw_valid} = 6'h00;
      {sync2_det, cw_valid, cw_err} = 3'h0;
      {paddr, pwdata, fiw_frame, fiw_cycle} = 51'h0;
      {sync2_rate, cw_info} = 23'h0;
      n_mismatch  = 0;
      checks_done = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      chk(40'(battery_save), 40'h1);
      for (int a = 0; a < 5; a++)
      begin
         apb(8'(a * 4), 1'b0, 32'h0);
         chk(40'(rd), 40'h0);
      end
      apb(8'h18, 1'b0, 32'h0);
      chk(40'({r, rd}), 40'h100000000);
      apb(A_FRAME, 1'b1, 32'h00000005);
      apb(A_ADDR1, 1'b1, {11'h0, MY_A});
      apb(A_FRAME, 1'b0, 32'h0);
      chk(40'(rd), 40'h5);
      frame(RATE_6400, 1'b1, 4'h0);
      frame(RATE_3200, 1'b1, MAX_CYCLE);
      frame(RATE_1600, 1'b0, 4'h0);
      // Unassigned frame, then a cycle number out of range.
      for (int k = 0; k < 2; k++)
      begin
         host.got.delete();
         syncs((k == 0) ? 7'h06 : 7'h05, (k == 0) ? 4'h0 : 4'hF, RATE_1600);
         repeat (3) @(posedge pclk);
         for (int n = 0; n < 8; n++)
            send_cw(word_of(2'h0, n));
         cw_valid <= 1'b0;
         repeat (20) @(posedge pclk);
         chk({39'h0, battery_save}, 40'h1);
         chk(40'(host.got.size()), 40'h0);
      end
      // Status shows the refused frame: save on, not in data, cycle kept.
      apb(A_STATUS, 1'b0, 32'h0);
      chk(40'(rd), 40'({17'h0, 1'b1, 1'b0, RATE_1600, 4'hF, 7'h05}));
      finish_test();
   end
endmodule
